// File: rtl/asq_scan_seq.sv
// Scan sequencer top: registers, channel walk, result capture, irq request.
`timescale 1ns/10ps
// How it works
// [R1] Request irq on flag when enabled, higher priority.
// [R2] Only software clears the completion flag.
// [R3] Control bit 2 picks continuous or single.
// [R4] Writing start bit one begins the scan.
// [R5] Start bit stays set while converting.
// [R6] Start while running is ignored.
// [R7] Clearing start bit aborts the scan.
// [R8] Completion flag set after all selected converted.
// [R9] Software keeps reserved bits at zero.
// [R10] Mask bit n enables channel n.
// [R11] Timing code is timing register low nibble.
// [R12] Sampling length comes from the code table.
// [R13] Conversion length comes from the code table.
// [R14] Codes 6 and B double sampling time.
// [R15] Unselected channels are skipped.
// [R16] Result stored in converted channel's register.
// [R17] Continuous mode repeats; flag after first pass.
// [R18] Channels visited in ascending order.
// [R19] Empty mask ends scan at once with flag.
module asq_scan_seq
    import asq_pkg::*;
(
    input  wire logic                  core_clk_in,
    input  wire logic                  sys_rst_in,
    input  wire logic [10:0]           sfr_addr_in,
    input  wire logic                  sfr_wr_in,
    input  wire logic [7:0]            sfr_wdata_in,
    input  wire logic                  sfr_rd_in,
    output logic      [7:0]            sfr_rdata_out,
    input  wire logic                  converter_irq_enable_in,
    input  wire logic                  global_irq_enable_in,
    input  wire logic [3:0]            irq_priority_in,
    input  wire logic [3:0]            running_priority_mask_in,
    input  wire logic [3:0]            pending_priority_in,
    input  wire logic                  cmp_in,
    output logic      [2:0]            mux_sel_out,
    output logic                       sample_out,
    output logic      [7:0]            sar_code_out,
    output logic      [7:0]            result_we_out,
    output logic      [ASQ_RES_W-1:0]  channel_result_out,
    output logic                       irq_req_out,
    output logic                       busy_out
);
    typedef enum logic [1:0] {
        ASQ_IDLE,
        ASQ_PICK,
        ASQ_CONV
    } asq_state_t;

    typedef struct packed {
        asq_state_t  state;
        logic [7:0]  ctrl;
        logic [7:0]  mask;
        logic [7:0]  timing;
        logic [2:0]  chan;
        logic [7:0]  sar;
        logic [7:0]  trial;
        logic [7:0]  code;
        logic [7:0]  rdata;
        logic [7:0]  we;
        logic [7:0]  res;
        logic        smp;
        logic        irq;
        logic        go;
    } asq_top_t;

    asq_top_t st_q;
    asq_top_t st_d;

    logic timer_smp;
    logic timer_done;
    logic sar_step;

    // Result width must fit the successive approximation register.
    if (ASQ_RES_W != 8 || ASQ_CHANNELS != 8) begin : g_bad_width
        $error("asq_scan_seq supports eight 8-bit channels only");
    end

    asq_conv_timer u_timer (
        .core_clk_in  (core_clk_in),
        .sys_rst_in   (sys_rst_in),
        .go_in        (st_q.go),
        .abort_in     (st_q.state == ASQ_IDLE),
        .code_in      (st_q.timing[ASQ_TIME_W-1:0]),           // [R11]
        .sampling_out (timer_smp),
        .done_out     (timer_done)
    );

    // One trial bit per clock after sampling; eight trials fit any code.
    assign sar_step = (st_q.state == ASQ_CONV) && !timer_smp
                      && !st_q.go && (st_q.trial != 8'h00);

    // Lowest selected channel at or above a start point.
    function automatic logic [3:0] next_chan(input logic [7:0] m,
                                             input logic [3:0] from);
        logic [3:0] r;
        r = 4'h8;
        for (int i = 7; i >= 0; i--) begin
            if (m[i] && (4'(i) >= from)) begin
                r = 4'(i);                                      // [R18] [R15]
            end
        end
        return r;
    endfunction

    // Register access, scan walk and request logic.
    always_comb begin
        logic       start_wr;
        logic       stop_wr;
        logic [3:0] nxt;
        logic       pass_end;
        start_wr = 1'b0;
        stop_wr  = 1'b0;
        nxt      = 4'h8;
        pass_end = 1'b0;
        st_d     = st_q;
        st_d.we  = 8'h00;
        st_d.go  = 1'b0;
        st_d.smp = timer_smp;
        // Register writes.
        if (sfr_wr_in) begin
            case (sfr_addr_in)
                ASQ_CTRL_ADDR: begin
                    st_d.ctrl[7:3] = sfr_wdata_in[7:3];         // [R9]
                    st_d.ctrl[ASQ_MODE_BIT] =
                        sfr_wdata_in[ASQ_MODE_BIT];             // [R3]
                    st_d.ctrl[ASQ_DONE_BIT] = st_q.ctrl[ASQ_DONE_BIT]
                        & sfr_wdata_in[ASQ_DONE_BIT];           // [R2]
                    start_wr = sfr_wdata_in[ASQ_START_BIT]
                        && !st_q.ctrl[ASQ_START_BIT];           // [R4] [R6]
                    stop_wr  = !sfr_wdata_in[ASQ_START_BIT]
                        && st_q.ctrl[ASQ_START_BIT];            // [R7]
                end
                ASQ_MASK_ADDR: begin
                    st_d.mask = sfr_wdata_in;                   // [R10]
                end
                ASQ_TIME_ADDR: begin
                    st_d.timing = sfr_wdata_in;                 // [R11]
                end
                default: begin
                end
            endcase
        end
        // Scan state machine.
        case (st_q.state)
            ASQ_IDLE: begin
                if (start_wr) begin
                    st_d.ctrl[ASQ_START_BIT] = 1'b1;            // [R5]
                    st_d.chan  = 3'h0;
                    st_d.state = ASQ_PICK;
                end
            end
            ASQ_PICK: begin
                nxt = next_chan(st_q.mask, {1'b0, st_q.chan});
                if (st_q.mask == 8'h00) begin
                    st_d.ctrl[ASQ_START_BIT] = 1'b0;            // [R19]
                    pass_end   = 1'b1;
                    st_d.state = ASQ_IDLE;
                end else if (nxt[3]) begin
                    pass_end = 1'b1;                            // [R8]
                    st_d.chan = 3'h0;
                    if (!st_q.ctrl[ASQ_MODE_BIT]) begin
                        st_d.ctrl[ASQ_START_BIT] = 1'b0;        // [R3]
                        st_d.state = ASQ_IDLE;
                    end                                         // [R17]
                end else begin
                    st_d.chan  = nxt[2:0];
                    st_d.sar   = 8'h00;
                    st_d.trial = 8'h80;
                    st_d.go    = 1'b1;
                    st_d.state = ASQ_CONV;
                end
            end
            ASQ_CONV: begin
                if (sar_step) begin
                    st_d.sar   = (st_q.sar | st_q.trial)
                                 & (cmp_in ? 8'hFF : ~st_q.trial);
                    st_d.trial = st_q.trial >> 1;
                end
                if (timer_done) begin
                    st_d.we[st_q.chan] = 1'b1;                  // [R16]
                    st_d.res   = st_q.sar;
                    st_d.state = ASQ_PICK;
                    st_d.chan = st_q.chan + 3'h1;
                    if (st_q.chan == 3'h7) begin
                        // Wrap means the pass is over; flag it here, as the mask walk does when no higher channel is selected.
                        st_d.chan  = 3'h0;
                        st_d.state = ASQ_PICK;
                        pass_end   = 1'b1;                      // [R8]
                        if (!st_q.ctrl[ASQ_MODE_BIT]) begin
                            st_d.ctrl[ASQ_START_BIT] = 1'b0;
                            st_d.state = ASQ_IDLE;
                        end
                    end
                end
            end
            default: begin
                st_d.state = ASQ_IDLE;
            end
        endcase
        // Software stop aborts any conversion in flight.
        if (stop_wr) begin
            st_d.ctrl[ASQ_START_BIT] = 1'b0;                    // [R7]
            st_d.state = ASQ_IDLE;
        end
        // Hardware set wins over a software clear in the same cycle.
        if (pass_end) begin
            st_d.ctrl[ASQ_DONE_BIT] = 1'b1;                     // [R8] [R2]
        end
        // Interrupt request, arbitrated against priority inputs.
        st_d.irq = st_q.ctrl[ASQ_DONE_BIT] && converter_irq_enable_in
            && global_irq_enable_in
            && (irq_priority_in > running_priority_mask_in)
            && (irq_priority_in > pending_priority_in);         // [R1]
        // Read data, reserved timing bits read as zero.
        case (sfr_addr_in)
            ASQ_CTRL_ADDR: st_d.rdata = st_q.ctrl;
            ASQ_MASK_ADDR: st_d.rdata = st_q.mask;
            ASQ_TIME_ADDR: st_d.rdata = {4'h0, st_q.timing[3:0]};
            default:       st_d.rdata = 8'h00;
        endcase
        if (!sfr_rd_in) begin
            st_d.rdata = st_q.rdata;
        end
        // Trial code is registered so the converter sees a clean flop.
        st_d.code = st_d.sar | st_d.trial;
    end

    // State register.
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_q        <= '0;
            st_q.state  <= ASQ_IDLE;
            st_q.ctrl   <= ASQ_CTRL_RST;
            st_q.mask   <= ASQ_MASK_RST;
            st_q.timing <= ASQ_TIME_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from flip-flops.
    assign sfr_rdata_out      = st_q.rdata;
    assign mux_sel_out        = st_q.chan;
    assign sample_out         = st_q.smp;
    assign sar_code_out       = st_q.code;
    assign result_we_out      = st_q.we;
    assign channel_result_out = st_q.res;
    assign irq_req_out        = st_q.irq;
    assign busy_out           = st_q.ctrl[ASQ_START_BIT];

    // Flag never falls without a software write.
    done_sticky_a: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        $fell(st_q.ctrl[ASQ_DONE_BIT]) |-> $past(sfr_wr_in)
        && $past(sfr_addr_in) == ASQ_CTRL_ADDR)                 // [R2]
        else $error("completion flag cleared by hardware");
    // Start while running leaves channel untouched.
    start_ignored_a: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        (st_q.state == ASQ_CONV && !timer_done && sfr_wr_in
         && sfr_addr_in == ASQ_CTRL_ADDR
         && sfr_wdata_in[ASQ_START_BIT]) |=> $stable(st_q.chan)) // [R6]
        else $error("running scan restarted");
    // Stop write aborts within one cycle.
    stop_abort_a: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        (busy_out && sfr_wr_in && sfr_addr_in == ASQ_CTRL_ADDR
         && !sfr_wdata_in[ASQ_START_BIT])
        |=> st_q.state == ASQ_IDLE && !busy_out)                // [R7]
        else $error("stop did not abort scan");
    // Irq follows flag and enables one cycle later.
    irq_gate_a: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        irq_req_out |-> $past(st_q.ctrl[ASQ_DONE_BIT])
        && $past(global_irq_enable_in)
        && $past(converter_irq_enable_in))                      // [R1]
        else $error("irq without enabled flag");
    // Result written only for a selected channel.
    skip_unsel_a: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        (result_we_out != 8'h00) |-> (result_we_out & ~st_q.mask) == 8'h00
        || $changed(st_q.mask))                                  // [R15]
        else $error("unselected channel converted");
    // Sequencer out of idle implies the start bit is still set.
    busy_state_a: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        (st_q.state != ASQ_IDLE) |-> busy_out)                  // [R5]
        else $error("start bit low while scanning");
    // Empty mask ends at once with flag.
    empty_mask_a: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        (st_q.state == ASQ_PICK && st_q.mask == 8'h00 && !sfr_wr_in)
        |=> !busy_out && st_q.ctrl[ASQ_DONE_BIT])               // [R19]
        else $error("empty mask scan not ended");
    // Continuous mode keeps running after a pass.
    cont_keep_a: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        (st_q.state == ASQ_CONV && timer_done && st_q.ctrl[ASQ_MODE_BIT]
         && !sfr_wr_in) |=> busy_out)                           // [R17]
        else $error("continuous scan stopped");
endmodule // asq_scan_seq

// File: rtl/asq_pkg.sv
// Package with register map, field positions and timing tables for the scan sequencer.
package asq_pkg;
    // Special function register byte addresses.
    localparam logic [10:0] ASQ_CTRL_ADDR  = 11'h43E;
    localparam logic [10:0] ASQ_MASK_ADDR  = 11'h43F;
    localparam logic [10:0] ASQ_TIME_ADDR  = 11'h4B9;
    // Reset values.
    localparam logic [7:0]  ASQ_CTRL_RST   = 8'h00;
    localparam logic [7:0]  ASQ_MASK_RST   = 8'h00;
    localparam logic [7:0]  ASQ_TIME_RST   = 8'h00;
    // Field positions in converter_control.
    localparam int          ASQ_DONE_BIT   = 0;
    localparam int          ASQ_START_BIT  = 1;
    localparam int          ASQ_MODE_BIT   = 2;
    // Width of the timing code field taken from the timing register.
    localparam int          ASQ_TIME_W     = 4;
    // Sampling length in oscillator clocks per timing code, code 0 lowest.
    localparam logic [7:0] ASQ_SAMPLE_TBL [16] = '{
        8'h04, 8'h06, 8'h08, 8'h08, 8'h0A, 8'h0C, 8'h18, 8'h0E,
        8'h0E, 8'h10, 8'h12, 8'h20, 8'h14, 8'h14, 8'h16, 8'h18};
    // Total conversion length in oscillator clocks per timing code.
    localparam logic [7:0] ASQ_CONV_TBL [16] = '{
        8'h46, 8'h4E, 8'h52, 8'h62, 8'h66, 8'h6A, 8'h76, 8'h66,
        8'h7E, 8'h82, 8'h86, 8'h94, 8'h8A, 8'h98, 8'hAC, 8'hB0};
    // Channel count and result width.
    localparam int          ASQ_CHANNELS   = 8;
    localparam int          ASQ_RES_W      = 8;
endpackage

// File: rtl/asq_conv_timer.sv
// One conversion timer: sample phase then remaining conversion clocks.
`timescale 1ns/10ps
module asq_conv_timer
    import asq_pkg::*;
(
    input  wire logic                  core_clk_in,
    input  wire logic                  sys_rst_in,
    input  wire logic                  go_in,
    input  wire logic                  abort_in,
    input  wire logic [ASQ_TIME_W-1:0] code_in,
    output logic                       sampling_out,
    output logic                       done_out
);
    typedef struct packed {
        logic [7:0] cnt;
        logic [7:0] samp;
        logic       busy;
        logic       smp;
        logic       done;
    } asq_tmr_t;

    asq_tmr_t st_q;
    asq_tmr_t st_d;

    // Load the table lengths on go, then count down to the done pulse.
    always_comb begin
        st_d      = st_q;
        st_d.done = 1'b0;
        if (abort_in) begin
            st_d.busy = 1'b0;
            st_d.smp  = 1'b0;
        end else if (go_in && !st_q.busy) begin
            st_d.busy = 1'b1;
            st_d.smp  = 1'b1;
            st_d.cnt  = ASQ_CONV_TBL[code_in] - 8'h01;         // [R13]
            st_d.samp = ASQ_CONV_TBL[code_in]
                        - ASQ_SAMPLE_TBL[code_in];              // [R12] [R14]
        end else if (st_q.busy) begin
            if (st_q.cnt == st_q.samp) begin
                st_d.smp = 1'b0;
            end
            if (st_q.cnt == 8'h00) begin
                st_d.busy = 1'b0;
                st_d.done = 1'b1;
            end else begin
                st_d.cnt = st_q.cnt - 8'h01;
            end
        end
    end

    // State register.
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sampling_out = st_q.smp;
    assign done_out     = st_q.done;
endmodule // asq_conv_timer

// File: tb/asq_analog_model.sv
// Behavioural analog front end: channel multiplexer, sample-and-hold, comparator.
`timescale 1ns/10ps
module asq_analog_model (
    input  wire logic        core_clk_in,
    input  wire logic [63:0] levels_in,
    input  wire logic [2:0]  mux_sel_in,
    input  wire logic        sample_in,
    input  wire logic [7:0]  sar_code_in,
    output logic             cmp_out
);
    logic [7:0] held_q = 8'h00;

    // The hold capacitor follows the selected input only while sampling.
    always @(posedge core_clk_in) begin
        if (sample_in) begin
            held_q <= levels_in[mux_sel_in*8 +: 8];
        end
    end

    // A trial bit is kept when the held level reaches the trial code.
    assign cmp_out = (held_q >= sar_code_in);
endmodule // asq_analog_model

// File: tb/adc_scan_sequencer_bench.sv
// Self-checking bench for the scan sequencer and its analog front-end model.
`timescale 1ns/10ps
module adc_scan_sequencer_bench;
    import asq_pkg::*;
    logic        core_clk_in = 1'b0;
    logic        sys_rst_in  = 1'b1;
    logic [10:0] addr        = 11'h000;
    logic        wr          = 1'b0;
    logic [7:0]  wdata       = 8'h00;
    logic        rd          = 1'b0;
    logic        cen         = 1'b1;
    logic        gen         = 1'b1;
    logic [3:0]  prio        = 4'hF;
    logic [3:0]  run_pri     = 4'h0;
    logic [3:0]  pend_pri    = 4'h0;
    logic [63:0] levels      = 64'hC37F8001A55AFF00;
    logic [7:0]  rdata, sar_code, result_we, result;
    logic [2:0]  mux_sel;
    logic        cmp, sample, irq, busy;
    int          fails       = 0;
    int          cmp_count   = 0;
    int          nres;
    // Rows: timing code, channel mask, sample clocks, conversion clocks.
    logic [31:0] rows [16] = '{
        32'h00010446, 32'h0180064E, 32'h02A50852, 32'h03FF0862,
        32'h045A0A66, 32'h05020C6A, 32'h06401876, 32'h07C30E66,
        32'h08100E7E, 32'h09081082, 32'h0A241286, 32'h0B812094,
        32'h0C18148A, 32'h0D661498, 32'h0E3C16AC, 32'h0F0418B0};
    // Irq rows: enable, global enable, priority, running, pending, expected.
    logic [14:0] irq_rows [6] = '{
        {2'b11, 4'h5, 4'h4, 4'h4, 1'b1}, {2'b01, 4'hF, 4'h0, 4'h0, 1'b0},
        {2'b10, 4'hF, 4'h0, 4'h0, 1'b0}, {2'b11, 4'h4, 4'h4, 4'h0, 1'b0},
        {2'b11, 4'h4, 4'h0, 4'h4, 1'b0}, {2'b11, 4'h1, 4'h0, 4'h0, 1'b1}};

    // Free-running 20 MHz oscillator clock.
    always #25 core_clk_in = ~core_clk_in;

    asq_scan_seq asq_scan_seq_inst (
        .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
        .sfr_addr_in(addr), .sfr_wr_in(wr), .sfr_wdata_in(wdata),
        .sfr_rd_in(rd), .sfr_rdata_out(rdata),
        .converter_irq_enable_in(cen), .global_irq_enable_in(gen),
        .irq_priority_in(prio), .running_priority_mask_in(run_pri),
        .pending_priority_in(pend_pri), .cmp_in(cmp),
        .mux_sel_out(mux_sel), .sample_out(sample), .sar_code_out(sar_code),
        .result_we_out(result_we), .channel_result_out(result),
        .irq_req_out(irq), .busy_out(busy));

    asq_analog_model asq_analog_model_inst (
        .core_clk_in(core_clk_in), .levels_in(levels),
        .mux_sel_in(mux_sel), .sample_in(sample),
        .sar_code_in(sar_code), .cmp_out(cmp));

    // Compares one byte and counts the outcome.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input string msg);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: %s seen %h expected %h",
                     $time, msg, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // A write strobe lasts one cycle; each call first waits a fresh edge.
    task automatic sfr_write(input logic [10:0] a, input logic [7:0] d);
        @(negedge core_clk_in);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge core_clk_in);
        wr = 1'b0;
    endtask

    // Read data is registered on the edge after the strobe.
    task automatic rd_chk(input logic [10:0] a, input logic [7:0] exp,
                          input string msg);
        @(negedge core_clk_in);
        addr = a;
        rd = 1'b1;
        @(negedge core_clk_in);
        rd = 1'b0;
        check(rdata, exp, msg);
    endtask

    // Next selected channel above the last one, wrapping for repeated passes.
    function automatic int next_ch(input logic [7:0] m, input int from);
        for (int i = 1; i <= 8; i++) begin
            if (m[(from + i) % 8]) return (from + i) % 8;
        end
        return 0;
    endfunction

    // Runs one scan and checks every result strobe; an optional control
    // write lands poke_at cycles after the start.
    task automatic scan(input logic [7:0] ctrl, input logic [7:0] mask,
                        input logic [7:0] samp, input logic [7:0] conv,
                        input int poke_at, input logic [7:0] poke_val);
        int cyc, start, scnt, ch;
        ch = -1;
        start = 0;
        scnt = 0;
        nres = 0;
        sfr_write(ASQ_MASK_ADDR, mask);
        sfr_write(ASQ_CTRL_ADDR, ctrl);
        for (cyc = 1; cyc < 3000; cyc++) begin
            @(negedge core_clk_in);
            wr = (cyc == poke_at);
            if (cyc == poke_at) begin
                addr = ASQ_CTRL_ADDR;
                wdata = poke_val;
            end
            if (sample === 1'b1) begin
                if (scnt == 0) start = cyc;
                scnt++;
            end
            if (result_we !== 8'h00) begin
                ch = next_ch(mask, ch);
                check(result_we, 8'h01 << ch, "strobe");
                check(result, levels[ch*8 +: 8], "result");
                check(8'(scnt), samp, "sample clocks");
                check(8'(cyc - start), conv, "conversion clocks");
                check({7'h00, irq}, {7'h00, nres >= $countones(mask)},
                      "irq in pass");
                nres++;
                scnt = 0;
            end
            if (cyc > 2 && busy !== 1'b1) break;
        end
        if (cyc >= 3000) begin
            fails++;
            results();
        end
    endtask

    // Main sequence: table of timing codes, then the awkward cases.
    initial begin
        repeat (8) @(negedge core_clk_in);
        sys_rst_in = 1'b0;
        foreach (rows[i]) begin
            sfr_write(ASQ_TIME_ADDR, rows[i][31:24]);
            scan(8'h02, rows[i][23:16], rows[i][15:8], rows[i][7:0], -1, 8'h00);
            check(8'(nres), 8'($countones(rows[i][23:16])), "count");
            rd_chk(ASQ_CTRL_ADDR, 8'h01, "single end");
        end
        repeat (100) @(negedge core_clk_in);
        rd_chk(ASQ_CTRL_ADDR, 8'h01, "flag holds");
        foreach (irq_rows[i]) begin
            @(negedge core_clk_in);
            {cen, gen, prio, run_pri, pend_pri} = irq_rows[i][14:1];
            repeat (2) @(negedge core_clk_in);
            check({7'h00, irq}, {7'h00, irq_rows[i][0]}, "irq gating");
        end
        {cen, gen, prio, run_pri, pend_pri} = 14'h3F00;
        sfr_write(ASQ_CTRL_ADDR, 8'h00);
        rd_chk(ASQ_CTRL_ADDR, 8'h00, "flag cleared by write");
        check({7'h00, irq}, 8'h00, "irq after clear");
        sfr_write(ASQ_CTRL_ADDR, 8'h01);
        rd_chk(ASQ_CTRL_ADDR, 8'h00, "flag not set by write");
        sfr_write(ASQ_TIME_ADDR, 8'h00);
        scan(8'h02, 8'h03, 8'h04, 8'h46, 20, 8'h02);
        check(8'(nres), 8'h02, "restart ignored");
        scan(8'h02, 8'h01, 8'h04, 8'h46, 30, 8'h00);
        check(8'(nres), 8'h00, "aborted result");
        rd_chk(ASQ_CTRL_ADDR, 8'h00, "aborted status");
        scan(8'h06, 8'h03, 8'h04, 8'h46, 400, 8'h04);
        check({7'h00, nres >= 4}, 8'h01, "continuous passes");
        rd_chk(ASQ_CTRL_ADDR, 8'h04, "continuous stopped");
        scan(8'h02, 8'h00, 8'h04, 8'h46, -1, 8'h00);
        check(8'(nres), 8'h00, "empty mask results");
        rd_chk(ASQ_CTRL_ADDR, 8'h01, "empty mask status");
        sfr_write(ASQ_TIME_ADDR, 8'hFF);
        rd_chk(ASQ_TIME_ADDR, 8'h0F, "timing nibble");
        rd_chk(11'h440, 8'h00, "unmapped read");
        sfr_write(ASQ_MASK_ADDR, 8'h01);
        sfr_write(ASQ_CTRL_ADDR, 8'h02);
        repeat (10) @(negedge core_clk_in);
        sys_rst_in = 1'b1;
        @(negedge core_clk_in);
        check({busy, irq, sample, 5'h00}, 8'h00, "outputs in reset");
        check(result_we, 8'h00, "strobe in reset");
        sys_rst_in = 1'b0;
        rd_chk(ASQ_CTRL_ADDR, ASQ_CTRL_RST, "control reset value");
        rd_chk(ASQ_MASK_ADDR, ASQ_MASK_RST, "mask reset value");
        rd_chk(ASQ_TIME_ADDR, ASQ_TIME_RST, "timing reset value");
        results();
    end
endmodule // adc_scan_sequencer_bench
